// [vic_top.sv]
// vectored interrupt controller with axi4-lite register slave
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps

module vic_top (
	// clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// axi4-lite write channels
	input  wire logic [vic_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	// axi4-lite read channels
	input  wire logic [vic_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// peripheral and trap event pulses
	input  wire logic [vic_pkg::NREQ-1:0]     req_event,
	input  wire logic [vic_pkg::NTRAP-1:0]    trap_event,
	// cpu sequencer
	output vic_pkg::vic_req_t                 cpu_req,
	input  wire logic                         cpu_ack,
	input  wire logic                         cpu_return,
	output logic [vic_pkg::LVL_W-1:0]         cpu_level
);
	import vic_pkg::*;

	// bus slave state
	logic                  aw_have_r;
	logic                  w_have_r;
	logic [AXI_AW-1:0]     waddr_r;
	logic [31:0]           wdata_r;
	logic [3:0]            wstrb_r;
	logic                  awready_r;
	logic                  wready_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  arready_r;
	logic                  rvalid_r;
	logic [31:0]           rdata_r;
	logic [1:0]            rresp_r;

	// controller state
	logic [NREQ-1:0]       flag_r;
	logic [NREQ-1:0]       en_r;
	logic [PRIO_W-1:0]     prio_r [NREQ];
	logic [NTRAP-1:0]      trap_r;
	logic                  alt_r;
	logic [LVL_W-1:0]      cpul_r;
	logic [LVL_W-1:0]      saved_lvl_r;
	logic [VEC_W-1:0]      taken_vec_r;
	logic [LVL_W-1:0]      taken_lvl_r;
	vic_req_t              req_r;
	vic_req_t              req_nxt;

	// bus handshakes
	wire                   aw_take = s_axi_awvalid & awready_r;
	wire                   w_take  = s_axi_wvalid & wready_r;
	wire                   ar_take = s_axi_arvalid & arready_r;
	wire                   wr_go   = aw_have_r & w_have_r & ~bvalid_r;
	wire                   aw_have_nxt = (aw_have_r & ~wr_go) | aw_take;
	wire                   w_have_nxt  = (w_have_r & ~wr_go) | w_take;
	wire                   bvalid_nxt  = (bvalid_r & ~s_axi_bready) | wr_go;
	wire                   rvalid_nxt  = (rvalid_r & ~s_axi_rready) | ar_take;
	wire [5:0]             wword = waddr_r[AXI_AW-1:2];
	wire [5:0]             rword = s_axi_araddr[AXI_AW-1:2];
	wire [31:0]            wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
	                                {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [31:0]            wd_m  = wdata_r & wmask;

	// write decode
	wire [FLAG_WORDS-1:0]  wr_flag;
	wire [FLAG_WORDS-1:0]  wr_en;
	wire [PRIO_WORDS-1:0]  wr_prio;
	wire                   wr_ctl2  = wr_go & (wword == OFS_CTL2[AXI_AW-1:2]);
	wire                   wr_cpul  = wr_go & (wword == OFS_CPUL[AXI_AW-1:2]);
	wire                   wr_trap  = wr_go & (wword == OFS_TRAP[AXI_AW-1:2]);
	wire                   wr_taken = wr_go & (wword == OFS_TAKEN[AXI_AW-1:2]);
	wire                   wr_hit   = (|wr_flag) | (|wr_en) | (|wr_prio) |
	                                  wr_ctl2 | wr_cpul | wr_trap | wr_taken;

	// read views
	wire [FLAG_WORDS*32-1:0] flag_flat = {{FLAG_PAD{1'b0}}, flag_r};
	wire [FLAG_WORDS*32-1:0] en_flat   = {{FLAG_PAD{1'b0}}, en_r};
	wire [PRIO_WORDS*32-1:0] prio_flat;
	assign prio_flat[PRIO_WORDS*32-1:NREQ*4] = {PRIO_PAD{1'b0}};

	genvar k;
	generate
		for (k = 0; k < FLAG_WORDS; k++) begin : g_fw
			assign wr_flag[k] = wr_go &
				(wword == OFS_FLAG[AXI_AW-1:2] + 6'(k));
			assign wr_en[k] = wr_go &
				(wword == OFS_EN[AXI_AW-1:2] + 6'(k));
		end
		for (k = 0; k < PRIO_WORDS; k++) begin : g_pw
			assign wr_prio[k] = wr_go &
				(wword == OFS_PRIO[AXI_AW-1:2] + 6'(k));
		end
	endgenerate

	// per-request flag, enable and level
	genvar i;
	generate
		for (i = 0; i < NREQ; i++) begin : g_src
			localparam int W  = i / 32;
			localparam int B  = i % 32;
			localparam int PW = i / 8;
			localparam int PN = i % 8;
			// a set in the clearing cycle wins over the clear
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					flag_r[i] <= 1'b0;
				end else begin
					flag_r[i] <= REQ_IMPL[i] & (req_event[i] |
						(flag_r[i] & ~(wr_flag[W] & wd_m[B])));
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					en_r[i] <= 1'b0;
				end else if (wr_en[W] & wmask[B]) begin
					en_r[i] <= wdata_r[B] & REQ_IMPL[i];
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					prio_r[i] <= PRIO_OFF;
				end else if (wr_prio[PW] & wstrb_r[PN/2]) begin
					prio_r[i] <= wdata_r[PN*4 +: PRIO_W];
				end
			end
			assign prio_flat[i*4 +: 4] = {1'b0, prio_r[i]};
		end
	endgenerate

	// read mux
	logic [31:0] rd_data;
	logic        rd_hit;
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (rword == OFS_CTL2[AXI_AW-1:2]) begin
			rd_data[ALT_SEL_BIT] = alt_r;
		end else if (rword == OFS_CPUL[AXI_AW-1:2]) begin
			rd_data[LVL_W-1:0] = cpul_r;
		end else if (rword == OFS_TAKEN[AXI_AW-1:2]) begin
			rd_data[VEC_W-1:0] = taken_vec_r;
			rd_data[TAKEN_LVL_POS +: LVL_W] = taken_lvl_r;
		end else if (rword == OFS_TRAP[AXI_AW-1:2]) begin
			rd_data[NTRAP-1:0] = trap_r;
		end else begin
			rd_hit = 1'b0;
		end
		for (int w = 0; w < FLAG_WORDS; w++) begin
			if (rword == OFS_FLAG[AXI_AW-1:2] + 6'(w)) begin
				rd_data = flag_flat[w*32 +: 32];
				rd_hit  = 1'b1;
			end
			if (rword == OFS_EN[AXI_AW-1:2] + 6'(w)) begin
				rd_data = en_flat[w*32 +: 32];
				rd_hit  = 1'b1;
			end
		end
		for (int w = 0; w < PRIO_WORDS; w++) begin
			if (rword == OFS_PRIO[AXI_AW-1:2] + 6'(w)) begin
				rd_data = prio_flat[w*32 +: 32];
				rd_hit  = 1'b1;
			end
		end
	end

	// arbitration: highest level first, then lowest request number
	logic [VEC_W-1:0]  best_idx;
	logic [PRIO_W-1:0] best_p;
	logic              best_hit;
	logic [VEC_W-1:0]  trap_idx;
	logic              trap_hit;
	wire [NTRAP-1:0]   trap_act = trap_r & TRAP_IMPL;
	always_comb begin
		best_idx = '0;
		best_p   = PRIO_OFF;
		best_hit = 1'b0;
		// walk downward so an equal level at a lower number takes over
		for (int n = NREQ - 1; n >= 0; n--) begin
			if (flag_r[n] & en_r[n] & (prio_r[n] != PRIO_OFF) &
			    (prio_r[n] >= best_p)) begin
				best_idx = VEC_W'(n);
				best_p   = prio_r[n];
				best_hit = 1'b1;
			end
		end
		trap_idx = '0;
		trap_hit = 1'b0;
		for (int n = NTRAP - 1; n >= 0; n--) begin
			if (trap_act[n]) begin
				trap_idx = VEC_W'(n);
				trap_hit = 1'b1;
			end
		end
	end

	// request record toward the cpu
	wire [ADDR_W-1:0] tbl_first = alt_r ? ALT_FIRST : PRI_FIRST;
	wire              trap_go = trap_hit & (cpul_r < TRAP_LEVEL);
	wire              user_go = best_hit & ({1'b0, best_p} > cpul_r);
	wire [VEC_W-1:0]  sel_vec = trap_go ? trap_idx :
	                            best_idx + REQ_VEC_BASE;
	always_comb begin
		req_nxt       = '0;
		req_nxt.valid = trap_go | user_go;
		req_nxt.vec   = sel_vec;
		req_nxt.addr  = tbl_first + {16'h0000, sel_vec, 1'b0};
		req_nxt.level = trap_go ? TRAP_LEVEL : {1'b0, best_p};
	end

	wire ack_go = cpu_ack & req_r.valid;

	// one registered stage each way keeps entry and return latency fixed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_r <= '0;
		end else if (ack_go) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			taken_vec_r <= '0;
			taken_lvl_r <= CPUL_RST;
			saved_lvl_r <= CPUL_RST;
		end else if (ack_go) begin
			taken_vec_r <= req_r.vec;
			taken_lvl_r <= req_r.level;
			saved_lvl_r <= cpul_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpul_r <= CPUL_RST;
		end else if (ack_go) begin
			cpul_r <= req_r.level;
		end else if (cpu_return) begin
			cpul_r <= saved_lvl_r;
		end else if (wr_cpul & wstrb_r[0]) begin
			cpul_r <= {cpul_r[LVL_W-1], wdata_r[LVL_W-2:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trap_r <= '0;
			alt_r  <= ALT_SEL_RST;
		end else begin
			trap_r <= TRAP_IMPL & (trap_event |
				(trap_r & ~({NTRAP{wr_trap}} & wd_m[NTRAP-1:0])));
			if (wr_ctl2 & wstrb_r[ALT_SEL_BIT/8]) begin
				alt_r <= wdata_r[ALT_SEL_BIT];
			end
		end
	end

	// axi4-lite write path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			awready_r <= ~aw_have_nxt & ~bvalid_nxt;
			wready_r  <= ~w_have_nxt & ~bvalid_nxt;
			bvalid_r  <= bvalid_nxt;
			if (wr_go) begin
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (aw_take) begin
				waddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	// axi4-lite read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= RESP_OKAY;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r  <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rd_data;
				rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign cpu_req       = req_r;
	assign cpu_level     = cpul_r;
endmodule

// [vic_pkg.sv]
// constants, register map and request record of the vectored interrupt controller
package vic_pkg;
	// request and trap slots
	localparam int NREQ       = 66;
	localparam int NTRAP      = 8;
	localparam int VEC_W      = 7;
	localparam int LVL_W      = 4;
	localparam int PRIO_W     = 3;
	localparam int ADDR_W     = 24;
	localparam int VEC_ENTRIES = 126;
	localparam logic [NREQ-1:0]  REQ_IMPL  = 66'h2_0000_0000_20DB_3FEF;
	localparam logic [NTRAP-1:0] TRAP_IMPL = 8'h1E;
	localparam logic [VEC_W-1:0] REQ_VEC_BASE = 7'h08;

	// program-memory addresses
	localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h00_0000;
	localparam logic [ADDR_W-1:0] PRI_FIRST  = 24'h00_0004;
	localparam logic [ADDR_W-1:0] ALT_BASE   = 24'h00_0100;
	localparam logic [ADDR_W-1:0] ALT_FIRST  = 24'h00_0104;
	localparam logic [ADDR_W-1:0] CODE_START = 24'h00_0200;

	// priority levels
	localparam logic [PRIO_W-1:0] PRIO_OFF   = 3'h0;
	localparam logic [LVL_W-1:0]  TRAP_LEVEL = 4'h8;
	localparam logic [LVL_W-1:0]  CPUL_RST   = 4'h0;

	// register byte offsets
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] OFS_FLAG  = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_EN    = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_PRIO  = 8'h20;
	localparam logic [AXI_AW-1:0] OFS_CTL2  = 8'h50;
	localparam logic [AXI_AW-1:0] OFS_CPUL  = 8'h54;
	localparam logic [AXI_AW-1:0] OFS_TAKEN = 8'h58;
	localparam logic [AXI_AW-1:0] OFS_TRAP  = 8'h5C;
	localparam int FLAG_WORDS = 3;
	localparam int PRIO_WORDS = 9;
	localparam int FLAG_PAD   = FLAG_WORDS * 32 - NREQ;
	localparam int PRIO_PAD   = PRIO_WORDS * 32 - NREQ * 4;

	// field positions and reset values
	localparam int ALT_SEL_BIT   = 15;
	localparam int TAKEN_LVL_POS = 8;
	localparam logic ALT_SEL_RST = 1'b0;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic              valid;
		logic [VEC_W-1:0]  vec;
		logic [ADDR_W-1:0] addr;
		logic [LVL_W-1:0]  level;
	} vic_req_t;
endpackage

// [vic_top_asserts.sv]
// port assertions of the vectored interrupt controller
`timescale 1ns/10ps
module vic_top_asserts (
	// clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// watched ports
	input wire logic                     s_axi_bvalid,
	input vic_pkg::vic_req_t             cpu_req,
	input wire logic                     cpu_ack,
	input wire logic                     cpu_return,
	input wire logic [vic_pkg::LVL_W-1:0] cpu_level
);
	import vic_pkg::*;
	wire             tk = cpu_ack && cpu_req.valid;
	wire [VEC_W-1:0] v  = cpu_req.vec;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_clr; tk |=> cpu_req == '0; endproperty
	a_clr: assert property (p_clr) else $error("request kept");
	property p_lvl; tk |=> cpu_level == $past(cpu_req.level); endproperty
	a_lvl: assert property (p_lvl) else $error("level not taken");
	property p_addr; cpu_req.valid |-> cpu_req.addr == 24'h00_0004 + 2 * v
		|| cpu_req.addr == 24'h00_0104 + 2 * v; endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_trap; cpu_req.valid && v < NTRAP |->
		cpu_req.level == TRAP_LEVEL; endproperty
	a_trap: assert property (p_trap) else $error("trap level");
	property p_user; cpu_req.valid && v >= NTRAP |->
		cpu_req.level > $past(cpu_level); endproperty
	a_user: assert property (p_user) else $error("masked request");
	property p_impl; cpu_req.valid |-> (v < NTRAP ? TRAP_IMPL[v[2:0]] :
		v < NTRAP + NREQ && REQ_IMPL[v - NTRAP]); endproperty
	a_impl: assert property (p_impl) else $error("reserved slot");
	property p_hold; !$past(cpu_ack) && !$past(cpu_return) &&
		!$rose(s_axi_bvalid) |-> $stable(cpu_level); endproperty
	a_hold: assert property (p_hold) else $error("level moved");
	property p_top; $rose(s_axi_bvalid) && !$past(cpu_ack) &&
		!$past(cpu_return) |-> cpu_level[3] == $past(cpu_level[3]);
	endproperty
	a_top: assert property (p_top) else $error("top bit written");
	c_trap: cover property (tk && v < NTRAP);
	c_alt: cover property (tk && cpu_req.addr[8]);
	c_ret: cover property (cpu_return);
endmodule

// [vic_cpu_model.sv]
// processor sequencer model that takes and returns interrupts
`timescale 1ns/10ps
module vic_cpu_model (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// request side
	input vic_pkg::vic_req_t cpu_req,
	output logic            cpu_ack,
	output logic            cpu_return,
	// response pacing
	input wire logic [2:0]  ack_dly,
	input wire logic [5:0]  ret_dly
);
	import vic_pkg::*;
	logic [5:0] cnt_r;
	logic       busy_r;
	// one handler at a time, no nesting
	always_ff @(posedge aclk) begin
		cpu_ack <= 1'b0;
		cpu_return <= 1'b0;
		if (!aresetn) begin
			cnt_r <= 6'h00;
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r + 6'h01;
			if (cnt_r == ret_dly) begin
				cpu_return <= 1'b1;
				busy_r <= 1'b0;
				cnt_r <= 6'h00;
			end
		end else if (cpu_req.valid) begin
			cnt_r <= cnt_r + 6'h01;
			if (cnt_r == {3'h0, ack_dly}) begin
				cpu_ack <= 1'b1;
				busy_r <= 1'b1;
				cnt_r <= 6'h00;
			end
		end
	end
endmodule

// [test_vectored_interrupt_controller.sv]
// testbench of the vectored interrupt controller against a software model
`timescale 1ns/10ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
	n_fail++; $display("[FAIL] %0t %s", $time, m); end end
module test_vectored_interrupt_controller;
	import vic_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	wire  [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, cpu_ack, cpu_return;
	logic [65:0] req_event = '0;
	logic [7:0]  trap_event = 8'h00;
	vic_req_t    cpu_req;
	logic [3:0]  cpu_level, m_cpul = 4'h0, m_tlvl = 4'h0;
	logic [2:0]  ack_dly = 3'h0;
	logic [5:0]  ret_dly = 6'h20;
	bit          m_flag[96], m_en[96], m_trap[8], impl_m[66], m_alt;
	int          m_lvl[72], m_tvec, n_fail, samples_checked;
	int          il[21] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13,
		16, 17, 19, 20, 22, 23, 29, 65};
	always #50 aclk = ~aclk;
	vic_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_event,
		.trap_event, .cpu_req, .cpu_ack, .cpu_return, .cpu_level);
	vic_cpu_model u_cpu (.aclk, .aresetn, .cpu_req, .cpu_ack,
		.cpu_return, .ack_dly, .ret_dly);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(bit wr, int a, logic [31:0] d, output logic [31:0] q,
		output logic [1:0] r);
		int k;
		k = 0;
		@(posedge aclk);
		if (wr) begin
			s_axi_awaddr <= 8'(a);
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= 8'(a);
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		`CHK(k < 50, 1'b1, "bus hang")
	endtask
	// expected word and mapped flag of a register
	function automatic logic [32:0] rv(int a);
		logic [32:0] v;
		int i;
		v = '0;
		for (i = 0; i < 32; i++) begin
			if (a < 'h0C) v[i] = m_flag[a * 8 + i];
			if (a >= 'h10 && a < 'h1C) v[i] = m_en[(a - 'h10) * 8 + i];
			if (a >= 'h20 && a <= 'h40 && i < 8)
				v[4 * i +: 3] = 3'(m_lvl[(a - 'h20) * 2 + i]);
			if (a == 'h5C && i < 8) v[i] = m_trap[i];
		end
		if (a == 'h50) v[15] = m_alt;
		if (a == 'h54) v[3:0] = m_cpul;
		if (a == 'h58) v[11:0] = {m_tlvl, 1'b0, 7'(m_tvec)};
		v[32] = a < 'h0C || (a >= 'h10 && a < 'h1C) ||
			(a >= 'h20 && a <= 'h40) || (a >= 'h50 && a <= 'h5C);
		return v;
	endfunction
	task automatic mrd(int a);
		logic [31:0] q;
		logic [1:0]  r;
		logic [32:0] v;
		v = rv(a);
		bus(0, a, 32'h0000_0000, q, r);
		`CHK(q, v[32] ? v[31:0] : 32'h0000_0000, "read data")
		`CHK(r, v[32] ? RESP_OKAY : RESP_SLVERR, "read resp")
	endtask
	task automatic mwr(int a, logic [31:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		logic [32:0] v;
		int          i;
		v = rv(a);
		bus(1, a, d, q, r);
		`CHK(r, v[32] ? RESP_OKAY : RESP_SLVERR, "write resp")
		for (i = 0; i < 32; i++) begin
			if (a < 'h0C && d[i]) m_flag[a * 8 + i] = 0;
			if (a >= 'h10 && a < 'h1C) m_en[(a - 'h10) * 8 + i] = d[i];
			if (a >= 'h20 && a <= 'h40 && i < 8)
				m_lvl[(a - 'h20) * 2 + i] = d[4 * i +: 3];
			if (a == 'h5C && i < 8 && d[i]) m_trap[i] = 0;
		end
		if (a == 'h50) m_alt = d[15];
		if (a == 'h54) m_cpul[2:0] = d[2:0];
	endtask
	task automatic pulse(logic [65:0] rq, logic [7:0] tp);
		int i;
		@(posedge aclk);
		req_event <= rq;
		trap_event <= tp;
		@(posedge aclk);
		req_event <= '0;
		trap_event <= 8'h00;
		for (i = 0; i < 66; i++) if (rq[i] && impl_m[i]) m_flag[i] = 1;
		for (i = 1; i < 5; i++) if (tp[i]) m_trap[i] = 1;
	endtask
	function automatic int win();
		int n, b, bl;
		b = -1;
		bl = m_cpul;
		for (n = 7; n >= 0; n--) if (m_trap[n] && m_cpul < 8) b = n;
		if (b >= 0) return b;
		for (n = 0; n < 66; n++) if (m_flag[n] && m_en[n] && m_lvl[n] > bl) begin
			b = n + 8;
			bl = m_lvl[n];
		end
		return b;
	endfunction
	// take every pending trap or enabled request whose level is above the cpu level, in order, clearing each in its handler
	task automatic drain(int lat);
		int w, k, sv, el;
		while (1) begin
			w = win();
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (!(cpu_ack === 1'b1 && cpu_req.valid === 1'b1) && k < 40);
			if (w < 0) begin
				`CHK(k, 40, "unexpected entry")
				return;
			end
			el = w < 8 ? 8 : m_lvl[w - 8];
			`CHK(cpu_req.vec, 7'(w), "vector")
			`CHK(cpu_req.addr, 24'((m_alt ? 'h104 : 'h4) + 2 * w), "addr")
			`CHK(cpu_req.level, 4'(el), "level")
			if (lat >= 0) `CHK(k, lat, "entry latency")
			lat = -1;
			sv = m_cpul;
			m_cpul = 4'(el);
			m_tvec = w;
			m_tlvl = 4'(el);
			mrd('h58);
			mrd('h54);
			if (w < 8) mwr('h5C, 32'h1 << w);
			else mwr((w - 8) / 32 * 4, 32'h1 << ((w - 8) % 32));
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (cpu_return !== 1'b1 && k < 80);
			@(posedge aclk);
			m_cpul = 4'(sv);
			`CHK(cpu_level, m_cpul, "level after return")
		end
	endtask
	initial begin
		int          i, j, s;
		logic [65:0] rq;
		s = $urandom(56823);
		for (i = 0; i < 21; i++) impl_m[il[i]] = 1;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(cpu_req, '0, "reset request")
		`CHK(cpu_level, 4'h0, "reset level")
		for (i = 0; i <= 'h64; i += 4) mrd(i);
		mwr('h64, 32'hFFFF_FFFF);
		mwr('h54, 32'h0000_000F);
		mrd('h54);
		mwr('h54, 32'h0000_0000);
		for (i = 0; i < 3; i++) mwr('h10 + 4 * i, 32'hFFFF_FFFF);
		for (i = 0; i < 21; i++) begin
			ack_dly <= 3'($urandom % 8);
			ret_dly <= 6'(30 + $urandom % 30);
			mwr('h50, 32'($urandom % 2) << 15);
			mwr('h20 + il[i] / 8 * 4, 32'(1 + $urandom % 7) << (il[i] % 8 * 4));
			pulse(66'h1 << il[i], 8'h00);
			drain(3 + ack_dly);
		end
		for (i = 0; i < 66; i++) rq[i] = !impl_m[i];
		pulse(rq, 8'hE1);
		drain(-1);
		for (i = 0; i < 3; i++) mrd(4 * i);
		for (j = 0; j < 12; j++) begin
			for (i = 0; i < 9; i++) mwr('h20 + 4 * i, $urandom);
			for (i = 0; i < 3; i++) mwr('h10 + 4 * i, $urandom);
			mwr('h54, $urandom % 7);
			mwr('h50, 32'($urandom % 2) << 15);
			for (i = 0; i < 66; i++) rq[i] = $urandom % 3 == 0;
			pulse(rq, 8'($urandom));
			drain(3 + ack_dly);
			for (i = 0; i < 3; i++) mwr(4 * i, 32'hFFFF_FFFF);
		end
		tally_and_finish();
	end
	initial begin
		#(100 * 60000);
		n_fail++;
		tally_and_finish();
	end
endmodule
bind vic_top vic_top_asserts u_chk (.aclk, .aresetn, .s_axi_bvalid,
	.cpu_req, .cpu_ack, .cpu_return, .cpu_level);
